// *** verilog/lss_sequencer.sv ***
// Load step sequencer with AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module lss_sequencer
	import lss_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [7:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic load_switch,
	input wire logic advance_key,
	input wire logic resume_input,
	output logic load_on_out,
	output logic [15:0] setpoint_out,
	output logic [1:0] mode_out,
	output logic [2:0] range_out,
	output logic step_pulse_output
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_have;
		logic w_have;
		logic bvalid;
		logic [1:0] bresp;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic seq_en;
		logic [3:0] start_slot;
		logic [3:0] edit_slot;
		logic [SLOTS-1:0][1:0] mode;
		logic [SLOTS-1:0][2:0] range;
		logic [SLOTS-1:0] hold_en;
		logic [SLOTS-1:0] infinite;
		logic [SLOTS-1:0][3:0] chain;
		logic [SLOTS-1:0][13:0] loops;
		logic [SLOTS-1:0][15:0] hold_lvl;
		logic [SLOTS-1:0][10:0] count;
		logic [9:0] sel;
		logic [15:0] st_val;
		logic [15:0] st_time;
		logic [3:0] st_flags;
		lss_run_t run;
		logic load_prev;
		logic [3:0] slot;
		logic [9:0] idx;
		logic [13:0] loop;
		logic [15:0] target;
		logic [15:0] time_ms;
		logic [15:0] elapsed;
		logic [15:0] start_lvl;
		logic [15:0] diff_mag;
		logic up;
		logic [3:0] flags;
		logic [23:0] tick;
		logic [15:0] trig_cnt;
		logic load_on;
		logic pulse;
		logic [15:0] setpoint;
		logic [1:0] mode_o;
		logic [2:0] range_o;
	} lss_top_state_t;

	lss_top_state_t q, d;
	logic mem_we;
	logic mem_re;
	logic [MEM_AW-1:0] mem_waddr;
	logic [MEM_AW-1:0] mem_raddr;
	logic [STEP_W-1:0] mem_wdata;
	logic [STEP_W-1:0] mem_rdata;
	logic div_start;
	logic [31:0] div_num;
	logic [15:0] div_den;
	logic div_done;
	logic [15:0] div_quo;

	function automatic logic [MEM_AW-1:0] step_addr(input logic [3:0] s, input logic [9:0] i);
		return MEM_AW'(s * MAX_STEPS) + MEM_AW'(i);
	endfunction : step_addr

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] strb);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = n[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	// Returns hit flag above the read word
	function automatic logic [32:0] reg_read(input lss_top_state_t s, input logic [7:0] a);
		logic [31:0] v;
		logic hit;
		v = 32'h00000000;
		hit = 1'b1;
		case (a)
			OFF_CTRL: begin
				v[CTRL_EN_BIT] = s.seq_en;
				v[CTRL_START_LSB +: 4] = s.start_slot;
			end
			OFF_STATUS: begin
				v[STAT_RUN_LSB +: 3] = s.run;
				v[STAT_SLOT_LSB +: 4] = s.slot;
				v[STAT_IDX_LSB +: 10] = s.idx;
			end
			OFF_RUN_LOOP: v[13:0] = s.loop;
			OFF_EDIT_SLOT: v[3:0] = s.edit_slot;
			OFF_SEQ_CFG: begin
				v[CFG_MODE_LSB +: 2] = s.mode[s.edit_slot];
				v[CFG_RANGE_LSB +: 3] = s.range[s.edit_slot];
				v[CFG_HOLD_BIT] = s.hold_en[s.edit_slot];
				v[CFG_INF_BIT] = s.infinite[s.edit_slot];
				v[CFG_CHAIN_LSB +: 4] = s.chain[s.edit_slot];
			end
			OFF_LOOP_CNT: v[13:0] = s.loops[s.edit_slot];
			OFF_HOLD_LVL: v[15:0] = s.hold_lvl[s.edit_slot];
			OFF_STEP_COUNT: v[10:0] = s.count[s.edit_slot];
			OFF_STEP_SEL: v[9:0] = s.sel;
			OFF_STEP_VAL: v[15:0] = s.st_val;
			OFF_STEP_TIME: v[15:0] = s.st_time;
			OFF_STEP_FLAGS: v[3:0] = s.st_flags;
			OFF_STEP_CMD: v = 32'h00000000;
			default: hit = 1'b0;
		endcase
		return {hit, v};
	endfunction : reg_read

	always_comb begin
		logic [31:0] wv;
		logic [32:0] rr;
		logic [10:0] cnt;
		logic [3:0] es;
		logic cfg_ok;
		logic go_next;
		logic last_step;
		logic more_loops;
		logic chain_ok;
		logic [3:0] nxt;
		wv = 32'h00000000;
		rr = 33'h000000000;
		es = q.edit_slot;
		cnt = q.count[q.edit_slot];
		cfg_ok = (q.run == RS_IDLE) || (q.run == RS_DONE);
		go_next = 1'b0;
		nxt = q.chain[q.slot];
		last_step = (11'(q.idx) + 11'h001) >= q.count[q.slot];
		more_loops = q.infinite[q.slot] || ((q.loop + 14'h0001) < q.loops[q.slot]);
		chain_ok = !q.infinite[q.slot] && (nxt < 4'(SLOTS)) && (q.count[nxt] != 11'h000);
		d = q;
		mem_we = 1'b0;
		mem_waddr = step_addr(es, q.sel);
		mem_wdata = {q.st_flags, q.st_time, q.st_val};
		mem_re = 1'b0;
		mem_raddr = step_addr(q.slot, q.idx);
		div_start = 1'b0;
		div_num = 32'(q.diff_mag) * 32'(q.elapsed + 16'h0001);
		div_den = q.time_ms;

		// Write channel: address and data are taken in either order
		if (s_axil_awvalid && q.awready) begin
			d.aw_have = 1'b1;
			d.awaddr = s_axil_awaddr;
		end
		if (s_axil_wvalid && q.wready) begin
			d.w_have = 1'b1;
			d.wdata = s_axil_wdata;
			d.wstrb = s_axil_wstrb;
		end
		if (q.bvalid && s_axil_bready) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_have && q.w_have && !q.bvalid) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			rr = reg_read(q, q.awaddr);
			d.bresp = rr[32] ? RESP_OKAY : RESP_SLVERR;
			wv = merge(rr[31:0], q.wdata, q.wstrb);
			case (q.awaddr)
				OFF_CTRL: begin
					d.seq_en = wv[CTRL_EN_BIT];
					if (wv[CTRL_START_LSB +: 4] < 4'(SLOTS)) begin
						d.start_slot = wv[CTRL_START_LSB +: 4];
					end
				end
				OFF_EDIT_SLOT: begin
					if (cfg_ok && wv[3:0] < 4'(SLOTS)) begin
						d.edit_slot = wv[3:0];
						d.sel = 10'h000;
					end
				end
				OFF_SEQ_CFG: begin
					if (cfg_ok) begin
						d.mode[es] = wv[CFG_MODE_LSB +: 2];
						if (wv[CFG_RANGE_LSB +: 3] <= RANGE_LAST) begin
							d.range[es] = wv[CFG_RANGE_LSB +: 3];
						end
						d.hold_en[es] = wv[CFG_HOLD_BIT];
						d.infinite[es] = wv[CFG_INF_BIT];
						if (wv[CFG_CHAIN_LSB +: 4] < 4'(SLOTS)) begin
							d.chain[es] = wv[CFG_CHAIN_LSB +: 4];
						end else begin
							d.chain[es] = CHAIN_OFF;
						end
					end
				end
				OFF_LOOP_CNT: begin
					if (cfg_ok && wv[13:0] != 14'h0000 && wv[13:0] <= 14'(LOOP_MAX)) begin
						d.loops[es] = wv[13:0];
					end
				end
				OFF_HOLD_LVL: begin
					if (cfg_ok) begin
						d.hold_lvl[es] = wv[15:0];
					end
				end
				OFF_STEP_SEL: begin
					if ({1'b0, wv[9:0]} < cnt) begin
						d.sel = wv[9:0];
					end
				end
				OFF_STEP_VAL: d.st_val = wv[15:0];
				OFF_STEP_TIME: d.st_time = wv[15:0];
				OFF_STEP_FLAGS: d.st_flags = wv[3:0];
				OFF_STEP_CMD: begin
					if (cfg_ok) begin
						if (wv[CMD_INSERT_BIT] && cnt < 11'(MAX_STEPS)) begin
							mem_we = 1'b1;
							mem_waddr = step_addr(es, cnt[9:0]);
							d.sel = cnt[9:0];
							d.count[es] = cnt + 11'h001;
						end else if (wv[CMD_UPDATE_BIT] && {1'b0, q.sel} < cnt) begin
							mem_we = 1'b1;
						end else if (wv[CMD_DELETE_BIT] && cnt != 11'h000) begin
							d.count[es] = cnt - 11'h001;
							if ({1'b0, q.sel} >= cnt - 11'h001) begin
								d.sel = (cnt > 11'h001) ? 10'(cnt - 11'h002) : 10'h000;
							end
						end
					end
				end
				default: d.bresp = RESP_SLVERR;
			endcase
		end
		d.awready = !d.aw_have;
		d.wready = !d.w_have;

		// Read channel: one read outstanding at a time
		if (q.rvalid && s_axil_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axil_arvalid && q.arready) begin
			rr = reg_read(q, s_axil_araddr);
			d.rdata = rr[31:0];
			d.rresp = rr[32] ? RESP_OKAY : RESP_SLVERR;
			d.rvalid = 1'b1;
		end
		d.arready = !d.rvalid;

		// Sequencer
		d.load_prev = load_switch;
		if (q.trig_cnt != 16'h0000) begin
			d.trig_cnt = q.trig_cnt - 16'h0001;
		end
		if (!load_switch) begin
			if (q.run != RS_IDLE) begin
				d.run = RS_IDLE;
				d.load_on = 1'b0;
				d.trig_cnt = 16'h0000;
			end
		end else begin
			case (q.run)
				RS_IDLE: begin
					if (!q.load_prev && q.seq_en) begin
						d.slot = q.start_slot;
						d.idx = 10'h000;
						d.loop = 14'h0000;
						d.run = (q.count[q.start_slot] == 11'h000) ? RS_DONE : RS_FETCH;
					end
				end
				RS_FETCH: begin
					mem_re = 1'b1;
					d.run = RS_WAIT;
				end
				RS_WAIT: begin
					d.target = mem_rdata[MEM_VAL_LSB +: 16];
					d.time_ms = mem_rdata[MEM_TIME_LSB +: 16];
					d.flags = mem_rdata[MEM_FLAGS_LSB +: 4];
					d.mode_o = q.mode[q.slot];
					d.range_o = q.range[q.slot];
					d.load_on = mem_rdata[MEM_FLAGS_LSB + FLG_LOAD_BIT];
					d.start_lvl = q.setpoint;
					d.up = mem_rdata[MEM_VAL_LSB +: 16] >= q.setpoint;
					d.diff_mag = (mem_rdata[MEM_VAL_LSB +: 16] >= q.setpoint) ?
						mem_rdata[MEM_VAL_LSB +: 16] - q.setpoint :
						q.setpoint - mem_rdata[MEM_VAL_LSB +: 16];
					if (!mem_rdata[MEM_FLAGS_LSB + FLG_RAMP_BIT]) begin
						d.setpoint = mem_rdata[MEM_VAL_LSB +: 16];
					end
					if (mem_rdata[MEM_FLAGS_LSB + FLG_TRIG_BIT]) begin
						d.trig_cnt = 16'(TRIG_CYCLES);
					end
					d.elapsed = 16'h0000;
					d.tick = 24'h000000;
					d.run = RS_RUN;
				end
				RS_RUN: begin
					if (div_done && q.flags[FLG_RAMP_BIT]) begin
						d.setpoint = q.up ? q.start_lvl + div_quo : q.start_lvl - div_quo;
					end
					if (q.tick == 24'(TICK_CYC - 1)) begin
						d.tick = 24'h000000;
						d.elapsed = q.elapsed + 16'h0001;
						if (q.elapsed + 16'h0001 >= q.time_ms) begin
							d.setpoint = q.target;
							if (q.flags[FLG_PAUSE_BIT]) begin
								d.run = RS_PAUSE;
							end else begin
								go_next = 1'b1;
							end
						end else if (q.flags[FLG_RAMP_BIT]) begin
							div_start = 1'b1;
						end
					end else begin
						d.tick = q.tick + 24'h000001;
					end
				end
				RS_PAUSE: begin
					if (advance_key || resume_input) begin
						go_next = 1'b1;
					end
				end
				RS_HOLD: d.run = RS_HOLD;
				RS_DONE: d.run = RS_DONE;
				default: d.run = RS_IDLE;
			endcase
		end
		if (go_next) begin
			d.run = RS_FETCH;
			if (!last_step) begin
				d.idx = q.idx + 10'h001;
			end else if (more_loops) begin
				d.idx = 10'h000;
				d.loop = q.loop + 14'h0001;
			end else if (chain_ok) begin
				d.slot = nxt;
				d.idx = 10'h000;
				d.loop = 14'h0000;
			end else if (!q.infinite[q.slot] && q.hold_en[q.slot]) begin
				d.run = RS_HOLD;
				d.setpoint = q.hold_lvl[q.slot];
				d.load_on = 1'b1;
			end else begin
				d.run = RS_DONE;
				d.load_on = 1'b0;
			end
		end
		d.pulse = d.trig_cnt != 16'h0000;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			q <= '0;
			q.loops <= {SLOTS{LOOP_RST}};
			q.chain <= {SLOTS{CHAIN_OFF}};
		end else begin
			q <= d;
		end
	end

	lss_step_mem #(
		.WIDTH(STEP_W),
		.DEPTH(SLOTS * MAX_STEPS),
		.AW(MEM_AW)
	) u_mem (
		.core_clk(core_clk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.re(mem_re),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	lss_div u_div (
		.core_clk(core_clk),
		.rst(rst),
		.start(div_start),
		.num(div_num),
		.den(div_den),
		.done(div_done),
		.quo(div_quo)
	);

	assign s_axil_awready = q.awready;
	assign s_axil_wready = q.wready;
	assign s_axil_bresp = q.bresp;
	assign s_axil_bvalid = q.bvalid;
	assign s_axil_arready = q.arready;
	assign s_axil_rdata = q.rdata;
	assign s_axil_rresp = q.rresp;
	assign s_axil_rvalid = q.rvalid;
	assign load_on_out = q.load_on;
	assign setpoint_out = q.setpoint;
	assign mode_out = q.mode_o;
	assign range_out = q.range_o;
	assign step_pulse_output = q.pulse;
endmodule : lss_sequencer

// *** verilog/lss_pkg.sv ***
// Shared constants and types for the load step sequencer
package lss_pkg;
	localparam int SLOTS = 10;
	localparam int MAX_STEPS = 1000;
	localparam int LOOP_MAX = 9999;
	localparam int MEM_AW = 14;
	localparam int STEP_W = 36;
	localparam int CLK_PERIOD_NS = 20;
	// Step times count in units of 1 ms
	localparam int TIME_UNIT_NS = 1000000;
	localparam int TICK_CYCLES = TIME_UNIT_NS / CLK_PERIOD_NS;
	localparam int TRIG_PULSE_NS = 10000;
	localparam int TRIG_CYCLES = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_RUN_LOOP = 8'h08;
	localparam logic [7:0] OFF_EDIT_SLOT = 8'h0C;
	localparam logic [7:0] OFF_SEQ_CFG = 8'h10;
	localparam logic [7:0] OFF_LOOP_CNT = 8'h14;
	localparam logic [7:0] OFF_HOLD_LVL = 8'h18;
	localparam logic [7:0] OFF_STEP_COUNT = 8'h1C;
	localparam logic [7:0] OFF_STEP_SEL = 8'h20;
	localparam logic [7:0] OFF_STEP_VAL = 8'h24;
	localparam logic [7:0] OFF_STEP_TIME = 8'h28;
	localparam logic [7:0] OFF_STEP_FLAGS = 8'h2C;
	localparam logic [7:0] OFF_STEP_CMD = 8'h30;

	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_START_LSB = 4;
	localparam int STAT_RUN_LSB = 0;
	localparam int STAT_SLOT_LSB = 4;
	localparam int STAT_IDX_LSB = 8;
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_RANGE_LSB = 2;
	localparam int CFG_HOLD_BIT = 5;
	localparam int CFG_INF_BIT = 6;
	localparam int CFG_CHAIN_LSB = 8;
	localparam int FLG_LOAD_BIT = 0;
	localparam int FLG_RAMP_BIT = 1;
	localparam int FLG_TRIG_BIT = 2;
	localparam int FLG_PAUSE_BIT = 3;
	localparam int CMD_INSERT_BIT = 0;
	localparam int CMD_UPDATE_BIT = 1;
	localparam int CMD_DELETE_BIT = 2;
	localparam int MEM_VAL_LSB = 0;
	localparam int MEM_TIME_LSB = 16;
	localparam int MEM_FLAGS_LSB = 32;

	localparam logic [3:0] CHAIN_OFF = 4'hF;
	localparam logic [13:0] LOOP_RST = 14'h0001;
	localparam logic [2:0] RANGE_LAST = 3'h5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		constant_current_mode = 2'b00,
		constant_resistance_mode = 2'b01,
		constant_voltage_mode = 2'b10,
		constant_power_mode = 2'b11
	} lss_mode_t;

	typedef enum logic [2:0] {
		low_current_low_voltage_range = 3'b000,
		high_current_low_voltage_range = 3'b001,
		low_current_high_voltage_range = 3'b010,
		high_current_high_voltage_range = 3'b011,
		low_conductance_high_voltage_range = 3'b100,
		high_conductance_low_voltage_range = 3'b101
	} lss_range_t;

	typedef enum logic [2:0] {
		RS_IDLE = 3'b000,
		RS_FETCH = 3'b001,
		RS_WAIT = 3'b010,
		RS_RUN = 3'b011,
		RS_PAUSE = 3'b100,
		RS_HOLD = 3'b101,
		RS_DONE = 3'b110
	} lss_run_t;
endpackage : lss_pkg

// *** verilog/lss_step_mem.sv ***
// Step storage for all sequence slots, registered read data
`timescale 1ns/1ps
module lss_step_mem #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 10000,
	parameter int AW = 14
) (
	input wire logic core_clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic re,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge core_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		if (re) begin
			rdata <= mem[raddr];
		end
	end
endmodule : lss_step_mem

// *** verilog/lss_div.sv ***
// Sequential restoring divider used for ramp interpolation
`timescale 1ns/1ps
module lss_div (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [31:0] num,
	input wire logic [15:0] den,
	output logic done,
	output logic [15:0] quo
);
	typedef struct packed {
		logic busy;
		logic done;
		logic [5:0] cnt;
		logic [16:0] rem;
		logic [31:0] acc;
	} lss_div_state_t;

	lss_div_state_t q, d;
	logic [16:0] trial;

	always_comb begin
		d = q;
		d.done = 1'b0;
		trial = {q.rem[15:0], q.acc[31]};
		if (start) begin
			d.busy = 1'b1;
			d.cnt = 6'h00;
			d.rem = 17'h00000;
			d.acc = num;
		end else if (q.busy) begin
			d.acc = {q.acc[30:0], 1'b0};
			d.rem = trial;
			if (trial >= {1'b0, den}) begin
				d.rem = trial - {1'b0, den};
				d.acc[0] = 1'b1;
			end
			d.cnt = q.cnt + 6'h01;
			if (q.cnt == 6'h1F) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done = q.done;
	assign quo = q.acc[15:0];
endmodule : lss_div

// *** tb/lss_sequencer_chk.sv ***
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module lss_sequencer_chk
	import lss_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic s_axil_awvalid,
	input wire logic s_axil_awready,
	input wire logic s_axil_wvalid,
	input wire logic s_axil_wready,
	input wire logic [1:0] s_axil_bresp,
	input wire logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [7:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	input wire logic s_axil_arready,
	input wire logic [31:0] s_axil_rdata,
	input wire logic [1:0] s_axil_rresp,
	input wire logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic load_switch,
	input wire logic load_on_out,
	input wire logic [15:0] setpoint_out,
	input wire logic [2:0] range_out,
	input wire logic step_pulse_output
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// Counts consecutive cycles of the trigger pulse
	logic [9:0] pc_q;
	logic [9:0] pc_d;
	always_comb pc_d = step_pulse_output ? pc_q + 10'h001 : 10'h000;
	always_ff @(posedge core_clk) begin
		if (rst) pc_q <= 10'h000;
		else pc_q <= pc_d;
	end
	sequence s_wtake;
		s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
	endsequence
	sequence s_rtake;
		s_axil_arvalid && s_axil_arready;
	endsequence
	AST_B_ANSWER: assert property (s_wtake |-> ##[1:2] s_axil_bvalid)
		else $error("write response missing");
	AST_AW_DROP: assert property (s_wtake |=> !s_axil_awready && !s_axil_wready)
		else $error("ready not dropped after write take");
	AST_B_HOLD: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
		else $error("write response not held");
	AST_R_ANSWER: assert property (s_rtake |=> s_axil_rvalid)
		else $error("read data missing");
	AST_R_HOLD: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
		else $error("read data not held");
	AST_R_SLVERR: assert property (s_rtake ##0 s_axil_araddr > 8'h30 |=> s_axil_rresp == RESP_SLVERR && s_axil_rdata == 32'h0)
		else $error("unmapped read not refused");
	AST_AR_BLOCK: assert property (s_axil_rvalid |-> !s_axil_arready)
		else $error("read address taken while data pending");
	AST_ABORT: assert property (!load_switch |=> !load_on_out && !step_pulse_output)
		else $error("load off did not stop the run");
	AST_RANGE: assert property (range_out <= RANGE_LAST)
		else $error("range code out of set");
	AST_PULSE_MAX: assert property (pc_q <= 10'(TRIG_CYCLES))
		else $error("trigger pulse too long");
	AST_PULSE_LEN: assert property ($fell(step_pulse_output) && load_switch && $past(load_switch) |-> pc_q == 10'(TRIG_CYCLES))
		else $error("trigger pulse too short");
	AST_RESET_OUT: assert property ($fell(rst) |-> !load_on_out && setpoint_out == 16'h0000)
		else $error("outputs not cleared by reset");
endmodule : lss_sequencer_chk

bind lss_sequencer lss_sequencer_chk #(.TICK_CYC(TICK_CYC)) lss_sequencer_chk_inst (.core_clk(core_clk),
	.rst(rst), .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
	.s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
	.s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready), .s_axil_araddr(s_axil_araddr),
	.s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
	.s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
	.load_switch(load_switch), .load_on_out(load_on_out), .setpoint_out(setpoint_out),
	.range_out(range_out), .step_pulse_output(step_pulse_output));

// *** tb/lss_far_model.sv ***
// Operator keys and trigger input facing the sequencer
`timescale 1ns/1ps
module lss_far_model (
	input wire logic core_clk,
	input wire logic on_req,
	input wire logic key_req,
	input wire logic trig_req,
	output logic load_switch,
	output logic advance_key,
	output logic resume_input
);
	always_ff @(posedge core_clk) begin
		load_switch <= on_req;
		advance_key <= key_req;
		resume_input <= trig_req;
	end
endmodule : lss_far_model

// *** tb/lss_sequencer_tb_top.sv ***
// Self-checking testbench for the load step sequencer
`timescale 1ns/1ps
module lss_sequencer_tb_top;
	import lss_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axil_awaddr = 8'h00;
	logic s_axil_awvalid = 1'b0;
	logic s_axil_awready;
	logic [31:0] s_axil_wdata = 32'h0;
	logic [3:0] s_axil_wstrb = 4'hF;
	logic s_axil_wvalid = 1'b0;
	logic s_axil_wready;
	logic [1:0] s_axil_bresp;
	logic s_axil_bvalid;
	logic s_axil_bready = 1'b0;
	logic [7:0] s_axil_araddr = 8'h00;
	logic s_axil_arvalid = 1'b0;
	logic s_axil_arready;
	logic [31:0] s_axil_rdata;
	logic [1:0] s_axil_rresp;
	logic s_axil_rvalid;
	logic s_axil_rready = 1'b0;
	logic load_switch, advance_key, resume_input, load_on_out, step_pulse_output;
	logic [15:0] setpoint_out;
	logic [1:0] mode_out;
	logic [2:0] range_out;
	logic on_req = 1'b0;
	logic key_req = 1'b0;
	logic trig_req = 1'b0;
	logic [31:0] d;
	logic [1:0] r;
	int fails = 0;
	int comparisons = 0;

	lss_sequencer #(.TICK_CYC(64)) lss_sequencer_inst (.core_clk, .rst, .s_axil_awaddr,
		.s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid,
		.s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
		.s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid,
		.s_axil_rready, .load_switch, .advance_key, .resume_input, .load_on_out,
		.setpoint_out, .mode_out, .range_out, .step_pulse_output);
	lss_far_model lss_far_model_inst (.core_clk, .on_req, .key_req, .trig_req, .load_switch,
		.advance_key, .resume_input);

	initial forever #10 core_clk = ~core_clk;

	task complete_run;
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task guard(input int k, input int lim);
		if (k >= lim) begin
			fails++;
			$display("Error at %0t: wait timed out", $time);
			complete_run();
		end
	endtask : guard

	task wr(input logic [7:0] a, input logic [31:0] v);
		int k;
		k = 0;
		@(posedge core_clk);
		s_axil_awaddr <= a;
		s_axil_awvalid <= 1'b1;
		s_axil_wdata <= v;
		s_axil_wvalid <= 1'b1;
		s_axil_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axil_awready) s_axil_awvalid <= 1'b0;
			if (s_axil_wready) s_axil_wvalid <= 1'b0;
			k++;
		end while (s_axil_bvalid !== 1'b1 && k < 100);
		guard(k, 100);
		r = s_axil_bresp;
		s_axil_bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		int k;
		k = 0;
		@(posedge core_clk);
		s_axil_araddr <= a;
		s_axil_arvalid <= 1'b1;
		s_axil_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axil_arready) s_axil_arvalid <= 1'b0;
			k++;
		end while (s_axil_rvalid !== 1'b1 && k < 100);
		guard(k, 100);
		d = s_axil_rdata;
		r = s_axil_rresp;
		s_axil_rready <= 1'b0;
	endtask : rd

	task wait_sp(input logic [15:0] v, input bit eq);
		int k;
		k = 0;
		while ((setpoint_out === v) != eq && k < 5000) begin
			@(posedge core_clk);
			k++;
		end
		guard(k, 5000);
	endtask : wait_sp

	task wait_st(input logic [2:0] s);
		int k;
		k = 0;
		do begin
			rd(OFF_STATUS);
			k++;
		end while (d[2:0] !== s && k < 3000);
		guard(k, 3000);
	endtask : wait_st

	task press(input bit trig);
		@(posedge core_clk);
		if (trig) trig_req <= 1'b1;
		else key_req <= 1'b1;
		@(posedge core_clk);
		key_req <= 1'b0;
		trig_req <= 1'b0;
	endtask : press

	task step_in(input logic [31:0] v, input logic [31:0] f);
		wr(OFF_STEP_VAL, v);
		wr(OFF_STEP_TIME, 32'h0000000A);
		wr(OFF_STEP_FLAGS, f);
		wr(OFF_STEP_CMD, 32'h1);
	endtask : step_in

	task test_regs;
		rd(OFF_LOOP_CNT);
		chk(d, 32'h1);
		rd(OFF_SEQ_CFG);
		chk(d & 32'h0F00, 32'h0F00);
		rd(8'h40);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(OFF_LOOP_CNT, 32'h0000270F);
		wr(OFF_LOOP_CNT, 32'h0);
		wr(OFF_LOOP_CNT, 32'h00002710);
		rd(OFF_LOOP_CNT);
		chk(d, 32'h0000270F);
		for (int m = 0; m < 4; m++) begin
			wr(OFF_SEQ_CFG, 32'(m));
			rd(OFF_SEQ_CFG);
			chk(d & 32'h3, 32'(m));
		end
		wr(OFF_SEQ_CFG, 32'h18);
		rd(OFF_SEQ_CFG);
		chk(d & 32'h1C, 32'h0);
		$display("test_regs finished");
	endtask : test_regs

	task test_run;
		wr(OFF_EDIT_SLOT, 32'h0);
		wr(OFF_LOOP_CNT, 32'h2);
		wr(OFF_HOLD_LVL, 32'h1234);
		wr(OFF_SEQ_CFG, 32'h0F2E);
		step_in(32'h0100, 32'h5);
		step_in(32'h0200, 32'hB);
		rd(OFF_STEP_COUNT);
		chk(d, 32'h2);
		wr(OFF_STEP_SEL, 32'h5);
		rd(OFF_STEP_SEL);
		chk(d, 32'h1);
		wr(OFF_CTRL, 32'h1);
		@(posedge core_clk);
		on_req <= 1'b1;
		wait_sp(16'h0100, 1'b1);
		chk({24'h0, load_on_out, step_pulse_output, 1'b0, mode_out, range_out}, 32'hD3);
		wait_sp(16'h0100, 1'b0);
		chk(32'(setpoint_out > 16'h0100 && setpoint_out < 16'h0200), 32'h1);
		wait_st(RS_PAUSE);
		chk({16'h0, setpoint_out}, 32'h0200);
		press(1'b0);
		wait_sp(16'h0100, 1'b1);
		rd(OFF_STATUS);
		chk(d & 32'h3FF00, 32'h0);
		wait_st(RS_PAUSE);
		press(1'b1);
		wait_st(RS_HOLD);
		chk({15'h0, load_on_out, setpoint_out}, 32'h0001_1234);
		$display("test_run finished");
	endtask : test_run

	task test_abort;
		@(posedge core_clk);
		on_req <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk({31'h0, load_on_out}, 32'h0);
		on_req <= 1'b1;
		wait_sp(16'h0100, 1'b1);
		on_req <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk({30'h0, load_on_out, step_pulse_output}, 32'h0);
		$display("test_abort finished");
	endtask : test_abort

	// Slot 1 loops forever with hold and a chain set: both must be ignored
	task test_chain;
		wr(OFF_EDIT_SLOT, 32'h00000001);
		wr(OFF_SEQ_CFG, 32'h00000060);
		step_in(32'h00000300, 32'h00000000);
		wr(OFF_CTRL, 32'h00000011);
		on_req <= 1'b1;
		wait_sp(16'h0300, 1'b1);
		chk({31'h0, load_on_out}, 32'h0);
		rd(OFF_STATUS);
		chk(d & 32'h000000FF, 32'h00000013);
		repeat (700) @(posedge core_clk);
		rd(OFF_STATUS);
		chk(d & 32'h000000FF, 32'h00000013);
		rd(OFF_RUN_LOOP);
		chk(d, 32'h00000001);
		on_req <= 1'b0;
		wait_st(RS_IDLE);
		$display("test_chain finished");
	endtask : test_chain

	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		test_regs();
		test_run();
		test_abort();
		test_chain();
		complete_run();
	end
endmodule : lss_sequencer_tb_top
